// ### hw/srs_pkg.sv
// Package with the status-reporting constants shared by the design files.
`default_nettype none
package srs_pkg;
   // ****************************************************************
   // Status byte layout.
   // ****************************************************************
   localparam int SB_W         = 8;
   localparam int SB_BUSY      = 0;
   localparam int SB_LIST_RUN  = 1;
   localparam int SB_ERRQ      = 2;
   localparam int SB_QS_SUM    = 3;
   localparam int SB_MAV       = 4;
   localparam int SB_ESB       = 5;
   localparam int SB_MSS       = 6;
   localparam int SB_OP_SUM    = 7;
   // ****************************************************************
   // Standard event register layout.
   // ****************************************************************
   localparam int ESR_OPC      = 0;
   localparam int ESR_QYE      = 2;
   localparam int ESR_DDE      = 3;
   localparam int ESR_EXE      = 4;
   localparam int ESR_CME      = 5;
   localparam int NUM_PROC     = 3;
   // ****************************************************************
   // Reset values and answer codes.
   // ****************************************************************
   localparam logic [7:0] SRM_RESET   = 8'h00;
   localparam logic [7:0] ESE_RESET   = 8'h00;
   localparam logic [7:0] ESR_RESET   = 8'h00;
   localparam logic [7:0] SRM_WR_MASK = 8'hBF;
   localparam logic [7:0] ASCII_ZERO  = 8'h30;
   localparam logic [7:0] ASCII_ONE   = 8'h31;
   localparam logic [7:0] BYTE_ZERO   = 8'h00;
   // Kind of answer last placed in the output queue.
   typedef enum logic [2:0] {
      SRS_ANS_NONE = 3'b000,
      SRS_ANS_OPC  = 3'b001,
      SRS_ANS_SB   = 3'b010,
      SRS_ANS_ESR  = 3'b011,
      SRS_ANS_SRM  = 3'b100,
      SRS_ANS_ESE  = 3'b101,
      SRS_ANS_POLL = 3'b110
   } srs_ans_t;
endpackage
`default_nettype wire

// ### hw/srs_stat_if.sv
// Interface carrying status conditions, masks and summaries between the design modules.
`default_nettype none
interface srs_stat_if;
   logic [7:0] cond;     // Status byte with bits 5 and 6 zero.
   logic [7:0] esr;
   logic [7:0] ese;
   logic [7:0] srm;
   logic       esb;
   logic       mss;
   logic [7:0] sbyte;    // Status byte with bit 6 = master summary.
   modport top (output cond, output esr, output ese, output srm,
                input esb, input mss, input sbyte);
   modport sum (input cond, input esr, input ese, input srm,
                output esb, output mss, output sbyte);
endinterface
`default_nettype wire

// ### hw/srs_summary.sv
// Combinational summary logic: event summary, master summary and status byte.
`default_nettype none
module srs_summary
   import srs_pkg::*;
(
   srs_stat_if.sum st
);
   // ****************************************************************
   // Summaries.
   // ****************************************************************
   logic [7:0] with_esb;

   // Enabled event bits are ORed into the event summary.
   always_comb begin
      st.esb   = |(st.esr & st.ese);
      with_esb = st.cond;
      with_esb[SB_ESB] = st.esb;
      with_esb[SB_MSS] = 1'b0;
      // Bit 6 of the mask never takes part, so only true causes count.
      st.mss   = |(with_esb & st.srm & SRM_WR_MASK);
      st.sbyte = with_esb;
      st.sbyte[SB_MSS] = st.mss;
   end
endmodule
`default_nettype wire

// ### hw/srs_status_core.sv
// Status-reporting and operation-complete logic with status byte and service request.
`default_nettype none
// Notes on behaviour
// - Operation-complete command clears event bit 0; set only when all work finishes.
// - Operation-complete query answers ASCII 0 while work pending, ASCII 1 when done.
// - Completion declared only when all three processors report idle.
// - Operation-complete command never stalls the command parser.
// - Status byte bits: op sum, mss/rqs, esb, mav, qs sum, errq, list, busy.
// - Service mask takes 0 to 255; bit 6 ignored on write.
// - Enabled status byte bits ORed into bit 6.
// - Serial poll clears request bit; master summary follows its condition.
// - Status byte query returns byte with master summary, changes nothing.
// - Serial poll returns byte with request bit in bit 6, then clears it.
// - Service mask query returns the stored mask.
// - Master summary high while any enabled cause remains, low otherwise.
// - Enabled event register bits ORed into event summary bit 5.
// - Event register query returns contents then clears them.
module srs_status_core
   import srs_pkg::*;
(
   // Clock and reset.
   input  wire logic                clk_sys_in,
   input  wire logic                sys_rst_in,
   // Decoded commands and queries, one-cycle pulses from the parser.
   input  wire logic                cmd_opc_in,
   input  wire logic                qry_opc_in,
   input  wire logic                cmd_cls_in,
   input  wire logic                qry_sb_in,
   input  wire logic                qry_esr_in,
   input  wire logic                cmd_srm_in,
   input  wire logic                qry_srm_in,
   input  wire logic                cmd_ese_in,
   input  wire logic                qry_ese_in,
   input  wire logic                serial_poll_in,
   input  wire logic [SB_W-1:0]     cmd_data_in,
   // Event pulses and condition levels from the instrument.
   input  wire logic [NUM_PROC-1:0] proc_idle_in,
   input  wire logic                ev_cmd_err_in,
   input  wire logic                ev_exe_err_in,
   input  wire logic                ev_dev_err_in,
   input  wire logic                ev_qry_err_in,
   input  wire logic                operation_summary_in,
   input  wire logic                questionable_summary_in,
   input  wire logic                error_queue_flag_in,
   input  wire logic                list_running_in,
   input  wire logic                busy_in,
   // Output queue, one byte deep.
   input  wire logic                resp_take_in,
   output logic [SB_W-1:0]          resp_data_out,
   output logic                     resp_valid_out,
   // Status and service request line (open drain).
   output logic [SB_W-1:0]          status_byte_out,
   output logic                     srq_line_out,
   output logic                     srq_oe_n_out,
   output logic                     cmd_ready_out
);
   // ****************************************************************
   // State.
   // ****************************************************************
   logic [7:0] srm_q;
   logic [7:0] ese_q;
   logic [7:0] esr_q;
   logic [7:0] esr_d;
   logic       opc_pending_q;
   logic       rqs_q;
   logic       mss_prev_q;
   logic       all_idle;
   logic       opc_done;
   logic [7:0] resp_q;
   logic       resp_valid_q;
   logic [7:0] sbyte_q;
   srs_ans_t   ans_q;
   srs_stat_if st ();

   srs_summary u_summary (
      .st (st)
   );

   // ****************************************************************
   // Summary inputs.
   // ****************************************************************
   // Message available comes from the queue flop, bit 6 is filled later.
   always_comb begin
      st.cond                 = BYTE_ZERO;
      st.cond[SB_BUSY]        = busy_in;
      st.cond[SB_LIST_RUN]    = list_running_in;
      st.cond[SB_ERRQ]        = error_queue_flag_in;
      st.cond[SB_QS_SUM]      = questionable_summary_in;
      st.cond[SB_MAV]         = resp_valid_q;
      st.cond[SB_OP_SUM]      = operation_summary_in;
      st.esr                  = esr_q;
      st.ese                  = ese_q;
      st.srm                  = srm_q;
   end

   // Completion needs every processor idle at once.
   assign all_idle = &proc_idle_in;
   assign opc_done = opc_pending_q && all_idle && !cmd_opc_in;

   // ****************************************************************
   // Operation complete tracking.
   // ****************************************************************
   // A fresh command restarts the wait; clear status abandons it.
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         opc_pending_q <= 1'b0;
      end else if (cmd_opc_in) begin
         opc_pending_q <= 1'b1;
      end else if (opc_done || cmd_cls_in) begin
         opc_pending_q <= 1'b0;
      end
   end

   // ****************************************************************
   // Standard event register.
   // ****************************************************************
   // New events are ORed in after the read clear, so a same-cycle event
   // survives the query that clears the register.
   always_comb begin
      esr_d = esr_q;
      if (qry_esr_in || cmd_cls_in) begin
         esr_d = ESR_RESET;
      end
      if (cmd_opc_in) begin
         esr_d[ESR_OPC] = 1'b0;
      end
      esr_d[ESR_OPC] = esr_d[ESR_OPC] | opc_done;
      esr_d[ESR_CME] = esr_d[ESR_CME] | ev_cmd_err_in;
      esr_d[ESR_EXE] = esr_d[ESR_EXE] | ev_exe_err_in;
      esr_d[ESR_DDE] = esr_d[ESR_DDE] | ev_dev_err_in;
      esr_d[ESR_QYE] = esr_d[ESR_QYE] | ev_qry_err_in;
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         esr_q <= ESR_RESET;
      end else begin
         esr_q <= esr_d;
      end
   end

   // ****************************************************************
   // Enable masks.
   // ****************************************************************
   // Bit 6 of the service mask is forced to zero whatever is written.
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         srm_q <= SRM_RESET;
      end else if (cmd_srm_in) begin
         srm_q <= cmd_data_in & SRM_WR_MASK;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         ese_q <= ESE_RESET;
      end else if (cmd_ese_in) begin
         ese_q <= cmd_data_in;
      end
   end

   // ****************************************************************
   // Request for service.
   // ****************************************************************
   // The request is raised by a new reason (rising master summary) and
   // dropped only by a poll; a new reason in the poll cycle wins.
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         mss_prev_q <= 1'b0;
         rqs_q      <= 1'b0;
      end else begin
         mss_prev_q <= st.mss;
         if (st.mss && !mss_prev_q) begin
            rqs_q <= 1'b1;
         end else if (serial_poll_in) begin
            rqs_q <= 1'b0;
         end
      end
   end

   // Open-drain line: pulled low while a request stands.
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         srq_oe_n_out <= 1'b1;
      end else begin
         srq_oe_n_out <= !(rqs_q || (st.mss && !mss_prev_q));
      end
   end

   // ****************************************************************
   // Output queue.
   // ****************************************************************
   // One answer per cycle; the parser issues one query at a time, the
   // poll wins if it coincides. A new answer overwrites an unread one.
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         resp_q       <= BYTE_ZERO;
         resp_valid_q <= 1'b0;
         ans_q        <= SRS_ANS_NONE;
      end else if (serial_poll_in) begin
         resp_q       <= {st.sbyte[SB_OP_SUM], rqs_q, st.sbyte[SB_ESB:0]};
         resp_valid_q <= 1'b1;
         ans_q        <= SRS_ANS_POLL;
      end else if (qry_opc_in) begin
         // Pending work answers zero; without a prior command it is one.
         resp_q       <= (opc_pending_q && !opc_done) ? ASCII_ZERO : ASCII_ONE;
         resp_valid_q <= 1'b1;
         ans_q        <= SRS_ANS_OPC;
      end else if (qry_sb_in) begin
         resp_q       <= st.sbyte;
         resp_valid_q <= 1'b1;
         ans_q        <= SRS_ANS_SB;
      end else if (qry_esr_in) begin
         resp_q       <= esr_q;
         resp_valid_q <= 1'b1;
         ans_q        <= SRS_ANS_ESR;
      end else if (qry_srm_in) begin
         resp_q       <= srm_q;
         resp_valid_q <= 1'b1;
         ans_q        <= SRS_ANS_SRM;
      end else if (qry_ese_in) begin
         resp_q       <= ese_q;
         resp_valid_q <= 1'b1;
         ans_q        <= SRS_ANS_ESE;
      end else if (resp_take_in) begin
         resp_valid_q <= 1'b0;
         ans_q        <= SRS_ANS_NONE;
      end
   end

   // ****************************************************************
   // Registered outputs.
   // ****************************************************************
   // The parser is never held off, also while completion is pending.
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         sbyte_q       <= BYTE_ZERO;
         cmd_ready_out <= 1'b0;
      end else begin
         sbyte_q       <= st.sbyte;
         cmd_ready_out <= 1'b1;
      end
   end

   assign resp_data_out   = resp_q;
   assign resp_valid_out  = resp_valid_q;
   assign status_byte_out = sbyte_q;
   assign srq_line_out    = 1'b0;
endmodule
`default_nettype wire

// ### test/srs_core_sva.sv
// Concurrent checks on the ports of the status-reporting core.
`default_nettype none
module srs_core_sva
   import srs_pkg::*;
(
   // Clock and reset.
   input wire logic             clk_sys_in,
   input wire logic             sys_rst_in,
   // Requests and levels driven into the core.
   input wire logic             cmd_srm_in,
   input wire logic             qry_opc_in,
   input wire logic             qry_sb_in,
   input wire logic             qry_esr_in,
   input wire logic             qry_srm_in,
   input wire logic             qry_ese_in,
   input wire logic             serial_poll_in,
   input wire logic             resp_take_in,
   input wire logic             busy_in,
   input wire logic             list_running_in,
   input wire logic             operation_summary_in,
   input wire logic             questionable_summary_in,
   input wire logic             error_queue_flag_in,
   input wire logic [SB_W-1:0]  cmd_data_in,
   // Outputs under watch.
   input wire logic [SB_W-1:0]  resp_data_out,
   input wire logic [SB_W-1:0]  status_byte_out,
   input wire logic             resp_valid_out,
   input wire logic             srq_line_out,
   input wire logic             srq_oe_n_out,
   input wire logic             cmd_ready_out
);
   // ****************************************************************
   // Helper state.
   // ****************************************************************
   // The mask shadow lets the summary bit be judged from the ports alone.
   logic [7:0] srm_q;
   logic [4:0] lvl_q;
   logic       live_q;
   logic       any_qry;
   assign any_qry = |{qry_opc_in, qry_sb_in, qry_esr_in, qry_srm_in, qry_ese_in, serial_poll_in};
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         srm_q  <= 8'h00;
         live_q <= 1'b0;
      end else begin
         live_q <= 1'b1;
         if (cmd_srm_in) begin
            srm_q <= cmd_data_in & SRM_WR_MASK;
         end
      end
   end
   // The status byte is registered, so its levels match last cycle's inputs.
   always_ff @(posedge clk_sys_in) begin
      lvl_q <= {operation_summary_in, questionable_summary_in, error_queue_flag_in,
                list_running_in, busy_in};
   end
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);
   // A poll while the summary stays high must leave no request behind.
   sequence poll_high_s;
      serial_poll_in && status_byte_out[6] ##1 status_byte_out[6];
   endsequence
   sequence srm_only_s;
      qry_srm_in && !serial_poll_in && !qry_opc_in && !qry_sb_in && !qry_esr_in;
   endsequence
   opc_answer_a: assert property (qry_opc_in && !serial_poll_in |=> resp_valid_out &&
      (resp_data_out == ASCII_ZERO || resp_data_out == ASCII_ONE)) else $error("bad opc answer");
   mask_answer_a: assert property (srm_only_s |=> resp_valid_out && !resp_data_out[6])
      else $error("mask answer has bit 6 set");
   take_clear_a: assert property (resp_take_in && !any_qry |=> !resp_valid_out)
      else $error("answer stays after take");
   poll_answer_a: assert property (serial_poll_in |=> resp_valid_out)
      else $error("poll gave no answer");
   srq_data_a: assert property (srq_line_out == 1'b0)
      else $error("srq data not low");
   parser_ready_a: assert property (!$past(sys_rst_in) |-> cmd_ready_out)
      else $error("parser stalled");
   status_levels_a: assert property (live_q |->
      {status_byte_out[7], status_byte_out[3:0]} == lvl_q) else $error("status levels wrong");
   summary_bit_a: assert property (live_q |-> status_byte_out[6] ==
      |(status_byte_out & $past(srm_q) & SRM_WR_MASK)) else $error("summary bit wrong");
   srq_drive_a: assert property ($rose(status_byte_out[6]) |-> ##[0:2] !srq_oe_n_out)
      else $error("srq not driven");
   poll_clear_a: assert property (poll_high_s |-> ##[0:2] srq_oe_n_out)
      else $error("srq kept after poll");
endmodule
bind srs_status_core srs_core_sva u_sva (.*);
`default_nettype wire

// ### test/srs_ctl_model.sv
// Bus controller model that reads answer bytes from the output queue.
`default_nettype none
module srs_ctl_model (
   // Clock and answer port.
   input  wire logic       clk_sys_in,
   input  wire logic       resp_valid_in,
   input  wire logic [7:0] resp_data_in,
   input  wire logic [3:0] stall_in,
   // Take strobe and copy of the byte read.
   output logic            resp_take_out,
   output logic            got_out,
   output logic [7:0]      got_data_out
);
   timeunit 1ns;
   timeprecision 1ns;
   int unsigned wait_q;
   logic        go;
   // Keeps watching the queue until a byte is there, then reads it after stall_in cycles.
   always @(posedge clk_sys_in) begin
      #1;
      go = (resp_valid_in === 1'b1) && (wait_q >= stall_in);
      wait_q = (resp_valid_in === 1'b1 && !go) ? wait_q + 1 : 0;
      resp_take_out = go;
      got_out = go;
      got_data_out = resp_data_in;
   end
   initial begin
      wait_q = 0;
      resp_take_out = 1'b0;
      got_out = 1'b0;
      got_data_out = 8'h00;
   end
endmodule
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the status-reporting core.
`default_nettype none
module tb import srs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************************************
   // Stimulus, answers and bookkeeping.
   // ****************************************************************
   logic       clk_sys_in = 1'b0, sys_rst_in = 1'b1;
   logic [9:0] strb = '0;
   logic [7:0] data = 8'h00, d, e_ans, exp_q[$];
   logic [2:0] idle = 3'b111;
   logic [3:0] ev = '0, stall = '0;
   logic [4:0] lv = '0;
   wire        take, got, resp_v, srq, oe_n, rdy;
   wire  [7:0] got_d, resp_d, sbyte;
   int         fails = 0, check_count = 0, cyc = 0, seed = 32'h498d;
   always #25 clk_sys_in = ~clk_sys_in;
   srs_status_core DUT (
      .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .cmd_opc_in(strb[0]),
      .qry_opc_in(strb[1]), .cmd_cls_in(strb[2]), .qry_sb_in(strb[3]),
      .qry_esr_in(strb[4]), .cmd_srm_in(strb[5]), .qry_srm_in(strb[6]),
      .cmd_ese_in(strb[7]), .qry_ese_in(strb[8]), .serial_poll_in(strb[9]),
      .cmd_data_in(data), .proc_idle_in(idle), .ev_qry_err_in(ev[0]),
      .ev_dev_err_in(ev[1]), .ev_exe_err_in(ev[2]), .ev_cmd_err_in(ev[3]),
      .busy_in(lv[0]), .list_running_in(lv[1]), .error_queue_flag_in(lv[2]),
      .questionable_summary_in(lv[3]), .operation_summary_in(lv[4]),
      .resp_take_in(take), .resp_data_out(resp_d), .resp_valid_out(resp_v),
      .status_byte_out(sbyte), .srq_line_out(srq), .srq_oe_n_out(oe_n), .cmd_ready_out(rdy));
   srs_ctl_model u_ctl (.clk_sys_in(clk_sys_in), .resp_valid_in(resp_v),
      .resp_data_in(resp_d), .stall_in(stall), .resp_take_out(take), .got_out(got),
      .got_data_out(got_d));
   task automatic chk(string n, logic [7:0] s, logic [7:0] x);
      check_count++;
      if (s !== x) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic wt(int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask
   // One strobe per call; the edge between calls keeps strobes from merging.
   task automatic op(int k, logic [7:0] v);
      wt(1);
      strb[k] = 1'b1;
      data = v;
      wt(1);
      strb = '0;
   endtask
   task automatic qry(int k, logic [7:0] x);
      exp_q.push_back(x);
      op(k, 8'h00);
      for (int i = 0; i < 40 && resp_v === 1'b1; i++) wt(1);
   endtask
   task automatic rst_pulse();
      sys_rst_in = 1'b1;
      wt(2);
      sys_rst_in = 1'b0;
      wt(1);
   endtask
   function automatic logic [7:0] sb_exp(logic [4:0] l, logic [7:0] m);
      logic [7:0] b;
      b = {l[4], 3'b000, l[3:0]};
      return b | {1'b0, |(b & m), 6'h00};
   endfunction
   task automatic end_sim();
      if (exp_q.size() != 0) fails++;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Each byte the controller reads is matched against the oldest note.
   always @(posedge clk_sys_in) begin
      if (got === 1'b1) begin
         e_ans = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
         chk("answer byte", got_d, e_ans);
      end
   end
   // A hang is cut short well above the two hundred or so cycles the run needs.
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         end_sim();
      end
   end
   initial begin
      rst_pulse();
      chk("status byte", sbyte, 8'h00);
      chk("srq enable", {7'h00, oe_n}, 8'h01);
      qry(6, 8'h00);
      idle = 3'b101;
      op(0, 8'h00);
      wt(3);
      chk("ready", {7'h00, rdy}, 8'h01);
      qry(1, ASCII_ZERO);
      qry(4, 8'h00);
      idle = 3'b111;
      wt(2);
      qry(1, ASCII_ONE);
      qry(4, 8'h01);
      qry(4, 8'h00);
      idle = 3'b000;
      op(0, 8'h00);
      op(2, 8'h00);
      idle = 3'b111;
      wt(2);
      qry(4, 8'h00);
      // Masks and levels from the seeded source, with both mask extremes first.
      for (int i = 0; i < 12; i++) begin
         d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
         lv = 5'($random(seed));
         op(5, d);
         qry(6, d & 8'hBF);
         wt(2);
         chk("status byte", sbyte, sb_exp(lv, d & 8'hBF));
      end
      lv = '0;
      rst_pulse();
      op(5, 8'h08);
      lv = 5'b01000;
      wt(4);
      chk("srq enable", {7'h00, oe_n}, 8'h00);
      chk("status byte", sbyte, 8'h48);
      qry(9, 8'h48);
      wt(3);
      chk("srq enable", {7'h00, oe_n}, 8'h01);
      chk("status byte", sbyte, 8'h48);
      qry(3, 8'h48);
      qry(9, 8'h08);
      lv = '0;
      wt(2);
      chk("status byte", sbyte, 8'h00);
      stall = 4'h6;
      exp_q.push_back(8'h00);
      op(3, 8'h00);
      wt(2);
      chk("status byte", sbyte, 8'h10);
      wt(8);
      chk("status byte", sbyte, 8'h00);
      stall = 4'h0;
      op(7, 8'h3C);
      qry(8, 8'h3C);
      for (int k = 0; k < 4; k++) begin
         ev[k] = 1'b1;
         wt(1);
         ev = '0;
         wt(2);
         chk("status byte", sbyte, 8'h20);
         qry(4, 8'h04 << k);
         wt(2);
         chk("status byte", sbyte, 8'h00);
      end
      end_sim();
   end
endmodule
`default_nettype wire
